/* inc/lit_rot_pkg.sv */
// Package for literal return and rotate execution logic
package lit_rot_pkg;
  localparam int          DATA_W       = 8;
  localparam int          FADDR_W      = 7;
  localparam int          PC_W         = 15;
  localparam logic [7:0]  W_RESET      = 8'h00;
  localparam logic [14:0] PC_RESET     = 15'h0000;
  localparam logic        CARRY_RESET  = 1'h0;
  localparam int          RET_CYCLES   = 2;
  localparam int          ROT_CYCLES   = 1;
  localparam logic [6:0]  FADDR_MAX    = 7'h7f;

  typedef enum logic [1:0] {
    OP_NONE   = 2'h0,
    OP_RETLIT = 2'h1,
    OP_ROTL   = 2'h2
  } op_e;

  typedef struct packed {
    op_e        op;
    logic [7:0] literal;
    logic [6:0] faddr;
    logic       dest;
  } instr_s;

  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } file_wr_s;
endpackage

/* logic/rotate_left_unit.sv */
// Combinational rotate left through carry
`timescale 1ns/1ps
module rotate_left_unit (
  input  wire logic [7:0] operand,
  input  wire logic       carry_in,
  output logic      [7:0] result,
  output logic            carry_out
);
  assign result    = {operand[6:0], carry_in}; // [RQ4]
  assign carry_out = operand[7]; // [RQ4]
endmodule // rotate_left_unit

/* logic/literal_return_and_rotate.sv */
// Execution logic for return with literal and rotate left through carry
// Notes on behaviour
// RQ1 - Return with literal loads the 8-bit literal into W, flags untouched.
// RQ2 - Return with literal loads the program counter from the stack top.
// RQ3 - Return with literal is one word and takes two instruction cycles.
// RQ4 - Rotate shifts left one; old carry enters bit 0, bit 7 becomes carry.
// RQ5 - Destination 0 sends the rotated result to W, register unchanged.
// RQ6 - Destination 1 writes the rotated result back to the source register.
// RQ7 - Rotate operand selected by 7-bit file address, 0 to 127.
// RQ8 - Returning pops the call stack so the next entry becomes the top.
// RQ9 - Rotate completes in one instruction cycle and is one word.
`timescale 1ns/1ps
module literal_return_and_rotate (
  input  wire logic                 clk,
  input  wire logic                 reset,
  input  wire lit_rot_pkg::instr_s  instr,
  input  wire logic                 instr_valid,
  input  wire logic [14:0]          stack_top,
  input  wire logic [7:0]           file_rdata,
  output logic      [6:0]           file_raddr,
  output lit_rot_pkg::file_wr_s     file_wr,
  output logic                      stack_pop,
  output logic                      busy,
  output logic                      flush,
  output logic      [7:0]           w_reg,
  output logic                      carry,
  output logic      [14:0]          pc
);
  typedef enum logic [1:0] {
    ST_IDLE   = 2'h0,
    ST_REFILL = 2'h1
  } state_e;

  state_e                state_q, state_d;
  logic   [7:0]          w_q, w_d;
  logic                  c_q, c_d;
  logic   [14:0]         pc_q, pc_d;
  lit_rot_pkg::file_wr_s wr_q, wr_d;
  logic                  pop_q, pop_d;
  logic   [7:0]          rot_res;
  logic                  rot_c;
  logic                  take;
  logic                  do_ret;
  logic                  do_rot;

  // Next sequential program counter
  function automatic logic [14:0] pc_inc(input logic [14:0] v);
    return v + 15'h0001;
  endfunction

  assign take       = instr_valid && (state_q == ST_IDLE);
  assign do_ret     = take && (instr.op == lit_rot_pkg::OP_RETLIT);
  assign do_rot     = take && (instr.op == lit_rot_pkg::OP_ROTL);
  assign file_raddr = instr.faddr; // [RQ7]

  rotate_left_unit u_rot (
    .operand   (file_rdata),
    .carry_in  (c_q),
    .result    (rot_res),
    .carry_out (rot_c)
  );

  always_comb begin
    state_d = state_q;
    w_d     = w_q;
    c_d     = c_q;
    pc_d    = pc_q;
    wr_d    = '0;
    pop_d   = 1'h0;
    case (state_q)
      ST_IDLE: begin
        if (do_ret) begin
          w_d     = instr.literal; // [RQ1]
          pc_d    = stack_top; // [RQ2]
          pop_d   = 1'h1; // [RQ8]
          state_d = ST_REFILL; // [RQ3]
        end else if (do_rot) begin
          c_d  = rot_c; // [RQ4]
          pc_d = pc_inc(pc_q); // [RQ9]
          if (!instr.dest) begin
            w_d = rot_res; // [RQ5]
          end else begin
            wr_d.we   = 1'h1; // [RQ6]
            wr_d.addr = instr.faddr; // [RQ6] [RQ7]
            wr_d.data = rot_res;
          end
        end else if (take) begin
          pc_d = pc_inc(pc_q);
        end
      end
      ST_REFILL: begin
        state_d = ST_IDLE; // [RQ3]
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= ST_IDLE;
      w_q     <= lit_rot_pkg::W_RESET;
      c_q     <= lit_rot_pkg::CARRY_RESET;
      pc_q    <= lit_rot_pkg::PC_RESET;
      wr_q    <= '0;
      pop_q   <= 1'h0;
    end else begin
      state_q <= state_d;
      w_q     <= w_d;
      c_q     <= c_d;
      pc_q    <= pc_d;
      wr_q    <= wr_d;
      pop_q   <= pop_d;
    end
  end

  assign w_reg     = w_q;
  assign carry     = c_q;
  assign pc        = pc_q;
  assign file_wr   = wr_q;
  assign stack_pop = pop_q;
  assign busy      = (state_q == ST_REFILL);
  assign flush     = (state_q == ST_REFILL);

  sequence s_ret_taken;
    instr_valid && !busy && instr.op == lit_rot_pkg::OP_RETLIT;
  endsequence

  sequence s_rot_taken;
    instr_valid && !busy && instr.op == lit_rot_pkg::OP_ROTL;
  endsequence

  sequence s_other_taken;
    instr_valid && !busy && instr.op != lit_rot_pkg::OP_RETLIT &&
      instr.op != lit_rot_pkg::OP_ROTL;
  endsequence

  sequence s_refill_step;
    busy && stack_pop && !file_wr.we ##1 !busy && !stack_pop;
  endsequence

  a_ret_loads_w: assert property (@(posedge clk) disable iff (reset) // [RQ1]
    s_ret_taken |=> (w_reg == $past(instr.literal)))
    else $error("literal not loaded into W");

  a_ret_keeps_carry: assert property (@(posedge clk) disable iff (reset) // [RQ1]
    s_ret_taken |=> $stable(carry))
    else $error("carry changed by literal return");

  a_ret_loads_pc: assert property (@(posedge clk) disable iff (reset) // [RQ2]
    s_ret_taken |=> (pc == $past(stack_top)))
    else $error("pc not loaded from stack top");

  a_ret_two_cycles: assert property (@(posedge clk) disable iff (reset) // [RQ3]
    s_ret_taken |=> busy ##1 !busy)
    else $error("literal return not two cycles");

  a_ret_pops_once: assert property (@(posedge clk) disable iff (reset) // [RQ8]
    s_ret_taken |=> stack_pop ##1 !stack_pop)
    else $error("stack not popped once");

  a_rot_carry_out: assert property (@(posedge clk) disable iff (reset) // [RQ4]
    s_rot_taken |=> (carry == $past(file_rdata[7])))
    else $error("rotate carry wrong");

  a_rot_to_w: assert property (@(posedge clk) disable iff (reset) // [RQ5]
    s_rot_taken ##0 !instr.dest |=>
      (w_reg == {$past(file_rdata[6:0]), $past(carry)}) && !file_wr.we)
    else $error("rotate to W wrong");

  a_rot_to_file: assert property (@(posedge clk) disable iff (reset) // [RQ6]
    s_rot_taken ##0 instr.dest |=> file_wr.we &&
      (file_wr.addr == $past(instr.faddr)) &&
      (file_wr.data == {$past(file_rdata[6:0]), $past(carry)}) && $stable(w_reg))
    else $error("rotate write back wrong");

  a_rot_one_cycle: assert property (@(posedge clk) disable iff (reset) // [RQ9]
    s_rot_taken |=> !busy && (pc == pc_inc($past(pc))))
    else $error("rotate not single cycle");

  a_raddr_field: assert property (@(posedge clk) disable iff (reset) // [RQ7]
    s_rot_taken |-> (file_raddr == instr.faddr) && (file_raddr <= lit_rot_pkg::FADDR_MAX))
    else $error("file address field wrong");

  a_ret_refill_walk: assert property (@(posedge clk) disable iff (reset) // [RQ3]
    s_ret_taken |=> s_refill_step)
    else $error("literal return refill walk wrong");

  a_busy_refuses: assert property (@(posedge clk) disable iff (reset) // [RQ3]
    busy |=> !busy && !file_wr.we && !stack_pop &&
      $stable(w_reg) && $stable(carry) && $stable(pc))
    else $error("instruction taken while busy");

  a_pop_after_ret: assert property (@(posedge clk) disable iff (reset) // [RQ8]
    stack_pop |-> $past(do_ret))
    else $error("stack popped without literal return");

  a_pop_one_cycle: assert property (@(posedge clk) disable iff (reset) // [RQ8]
    stack_pop |=> !stack_pop)
    else $error("stack pop longer than one cycle");

  a_rot_no_pop: assert property (@(posedge clk) disable iff (reset) // [RQ9]
    s_rot_taken |=> !stack_pop && !busy && !flush)
    else $error("rotate disturbed stack or pipeline");

  a_we_after_rot: assert property (@(posedge clk) disable iff (reset) // [RQ6]
    file_wr.we |-> $past(do_rot) && $past(instr.dest))
    else $error("write back without rotate to file");

  a_carry_by_rot: assert property (@(posedge clk) disable iff (reset) // [RQ4]
    $changed(carry) |-> $past(do_rot))
    else $error("carry changed outside rotate");

  a_w_writers: assert property (@(posedge clk) disable iff (reset) // [RQ5]
    $changed(w_reg) |-> $past(do_ret) || ($past(do_rot) && !$past(instr.dest)))
    else $error("W changed by wrong instruction");

  a_other_pc_step: assert property (@(posedge clk) disable iff (reset) // [RQ4]
    s_other_taken |=> $stable(w_reg) && $stable(carry) && !file_wr.we &&
      !stack_pop && !busy && (pc == pc_inc($past(pc))))
    else $error("other instruction changed state");

  a_idle_quiet: assert property (@(posedge clk) disable iff (reset) // [RQ8]
    !instr_valid && !busy |=> $stable(w_reg) && $stable(carry) && $stable(pc) &&
      !file_wr.we && !stack_pop)
    else $error("state changed with no instruction");
endmodule // literal_return_and_rotate

/* sim/literal_return_and_rotate_tb.sv */
// Self-checking bench for literal return and rotate
`timescale 1ns/1ps
module literal_return_and_rotate_tb;
  logic                  clk = 0, reset = 1, instr_valid = 0, m_c = 0, pw = 0;
  lit_rot_pkg::instr_s   instr = '0;
  logic [14:0]           stack_top = '0, m_pc = '0, pc;
  logic [7:0]            mem [128], m_w = '0, w_reg, pd;
  logic [6:0]            file_raddr, pa;
  logic                  stack_pop, busy, flush, carry;
  lit_rot_pkg::file_wr_s file_wr;
  logic [41:0]           q [$];
  logic [41:0]           n;
  int                    errors = 0, total_checks = 0;
  logic [31:0]           x = 32'h2;
  wire  [7:0]            file_rdata = mem[file_raddr];

  literal_return_and_rotate dut (.clk(clk), .reset(reset), .instr(instr),
    .instr_valid(instr_valid), .stack_top(stack_top), .file_rdata(file_rdata),
    .file_raddr(file_raddr), .file_wr(file_wr), .stack_pop(stack_pop), .busy(busy),
    .flush(flush), .w_reg(w_reg), .carry(carry), .pc(pc));

  initial forever #2 clk = ~clk;

  function automatic logic [31:0] rnd();
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction

  task chk(input logic [41:0] s, input logic [41:0] e);
    total_checks++;
    if (s !== e) begin
      errors++;
      $display("BAD %0t %h %h", $time, s, e);
    end
  endtask

  task print_verdict();
    if (errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Issue one instruction and note its expected outcome; a literal return also gets a refused rotate in its busy cycle
  task run(input logic [1:0] op, input logic [7:0] k, input logic [6:0] fa, input logic d);
    logic [7:0] r;
    @(posedge clk);
    #1;
    if (pw) mem[pa] = pd;
    pw = 0;
    r = {mem[fa][6:0], m_c};
    instr = '{lit_rot_pkg::op_e'(op), k, fa, d};
    instr_valid = 1;
    stack_top = 15'(rnd());
    if (op == 2'h1) begin
      m_w = k;
      m_pc = stack_top;
    end else m_pc = m_pc + 15'h1;
    if (op == 2'h2) begin
      m_c = mem[fa][7];
      if (!d) m_w = r;
      else begin
        pw = 1;
        pa = fa;
        pd = r;
      end
    end
    q.push_back({m_w, m_c, m_pc, op == 2'h1, op == 2'h1, pw, pw ? {pa, pd} : 15'h0});
    if (op == 2'h1) begin
      @(posedge clk);
      #1;
      instr = '{lit_rot_pkg::OP_ROTL, 8'h00, 7'h00, 1'h1};
      q.push_back({m_w, m_c, m_pc, 3'h0, 15'h0});
    end
  endtask

  initial forever begin
    @(posedge clk);
    if (q.size() > 0) begin
      n = q.pop_front();
      #2;
      chk(42'({w_reg, carry}), 42'(n[41:33]));
      chk(42'({pc, stack_pop, busy, flush}), 42'({n[32:16], n[16]}));
      chk(42'({file_wr.we, file_wr.we ? {file_wr.addr, file_wr.data} : 15'h0}),
          42'(n[15:0]));
    end
  end

  initial begin
    for (int i = 0; i < 128; i++) mem[i] = 8'(rnd());
    repeat (12) @(posedge clk);
    #1 reset = 0;
    chk(42'({w_reg, carry, pc, stack_pop, busy, flush, file_wr.we}),
        42'({lit_rot_pkg::W_RESET, lit_rot_pkg::CARRY_RESET, lit_rot_pkg::PC_RESET,
             4'h0}));
    mem[7'h05] = 8'he6;
    run(2'h2, 8'h00, 7'h05, 1'h0);
    run(2'h2, 8'h00, 7'h7f, 1'h1);
    run(2'h2, 8'h00, 7'h00, 1'h1);
    run(2'h1, 8'hff, 7'h00, 1'h0);
    run(2'h1, 8'h00, 7'h00, 1'h0);
    run(2'h0, 8'h00, 7'h00, 1'h0);
    run(2'h3, 8'h00, 7'h00, 1'h0);
    repeat (300) run(2'(rnd()), 8'(rnd()), 7'(rnd()), 1'(rnd()));
    @(posedge clk);
    #1 instr_valid = 0;
    repeat (3) @(posedge clk);
    print_verdict();
  end

  initial begin
    #20000;
    errors++;
    print_verdict();
  end
endmodule // literal_return_and_rotate_tb
